// *** hdl/adc_dac_pkg.sv ***
// Constants, register indices and bus carriers for the converter control block.
// Assumes an AXI4-Lite master with 32-bit data; each register sits at four times its index.
package adc_dac_pkg;
   localparam int ADDR_W = 8;
   localparam int SAMPLE_W = 16;
   localparam int DAC_W = 12;
   localparam int QUEUE_DEPTH = 1024;
   // Register indices; byte address is four times the index.
   localparam logic [4:0] IDX_RESULT = 5'h00;
   localparam logic [4:0] IDX_SOFT_TRIG = 5'h01;
   localparam logic [4:0] IDX_GAIN_FIRST = 5'h02;
   localparam logic [4:0] IDX_GAIN_LAST = 5'h05;
   localparam logic [4:0] IDX_RANGE = 5'h06;
   localparam logic [4:0] IDX_OVERSAMPLE = 5'h07;
   localparam logic [4:0] IDX_DAC_A_LO = 5'h0C;
   localparam logic [4:0] IDX_DAC_A_HI = 5'h0D;
   localparam logic [4:0] IDX_DAC_B_LO = 5'h0E;
   localparam logic [4:0] IDX_DAC_B_HI = 5'h0F;
   localparam logic [4:0] IDX_DAC_CTRL = 5'h10;
   localparam logic [4:0] IDX_TRIG_CFG = 5'h11;
   localparam logic [4:0] IDX_STATUS = 5'h12;
   // Field positions.
   localparam int CFG_SCAN_BIT = 2;
   localparam int CFG_EDGE_BIT = 3;
   localparam int CFG_CLK_BIT = 4;
   localparam int DAC_SIMUL_BIT = 0;
   localparam int ST_EMPTY_N_BIT = 5;
   localparam int ST_HALF_N_BIT = 6;
   localparam int ST_FULL_BIT = 7;
   // Reset values.
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {SRC_SOFT = 2'b00, SRC_TIMER = 2'b01, SRC_EXT = 2'b10} trig_src_e;
   typedef enum logic {SEQ_IDLE = 1'b0, SEQ_WAIT = 1'b1} seq_state_e;
   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [ADDR_W-1:0] araddr;
      logic arvalid;
      logic rready;
   } axil_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axil_rsp_s;
endpackage : adc_dac_pkg

// *** hdl/adc_dac_control_regs.sv ***
// Converter control block: AXI4-Lite registers, sample queue, scan sequencer and DAC loading.
// Assumes converter handshakes share aclk; counter outputs and jumpers are asynchronous pins.
`timescale 1ns/1ns
module adc_dac_control_regs #(
   parameter int DEPTH = adc_dac_pkg::QUEUE_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire adc_dac_pkg::axil_req_s axil_req,
   output adc_dac_pkg::axil_rsp_s axil_rsp,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic [1:0] conv_gain,
   input wire logic conv_done,
   input wire logic [adc_dac_pkg::SAMPLE_W-1:0] conv_data,
   input wire logic counter1_out,
   input wire logic counter2_out,
   output logic counter2_clk,
   output logic counter_zero_clock_select,
   input wire logic jumper_bipolar,
   input wire logic jumper_single_ended,
   input wire logic gain_group_jumper,
   input wire logic first_dac_range_flag,
   input wire logic second_dac_range_flag,
   output logic [adc_dac_pkg::DAC_W-1:0] dac_a_code,
   output logic [adc_dac_pkg::DAC_W-1:0] dac_b_code,
   output logic dac_a_load,
   output logic dac_b_load,
   output logic scan_busy
);
   import adc_dac_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] HALF_LEVEL = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

   // An address maps when word aligned and the index names a register of the right direction.
   function automatic logic idx_mapped(input logic [ADDR_W-1:0] addr, input logic is_write);
      logic [4:0] idx;
      logic ok;
      idx = addr[6:2];
      ok = (addr[1:0] == 2'b00) && !addr[7];
      if (is_write) begin
         idx_mapped = ok && ((idx >= IDX_SOFT_TRIG && idx <= IDX_OVERSAMPLE) ||
                             (idx >= IDX_DAC_A_LO && idx <= IDX_TRIG_CFG));
      end else begin
         idx_mapped = ok && (idx == IDX_RESULT || idx == IDX_SOFT_TRIG || idx == IDX_STATUS);
      end
   endfunction : idx_mapped

   // Asynchronous pins other than counter1_out pass two flip-flops before use.
   logic [5:0] pin_meta_reg;
   logic [5:0] pin_sync_reg;
   logic cnt2_prev_reg;
   always_ff @(posedge aclk) begin
      pin_meta_reg <= {counter2_out, second_dac_range_flag, first_dac_range_flag,
                       gain_group_jumper, jumper_single_ended, jumper_bipolar};
      pin_sync_reg <= pin_meta_reg;
      cnt2_prev_reg <= pin_sync_reg[5];
   end

   // Configuration registers written by software.
   logic [31:0] gain_reg;
   logic [7:0] range_reg;
   logic [7:0] oversample_reg;
   logic [7:0] trig_cfg_reg;
   logic dac_simul_reg;
   logic armed_reg;
   logic [7:0] dac_a_lo_reg;
   logic [3:0] dac_a_hi_reg;
   logic [7:0] dac_b_lo_reg;
   logic [DAC_W-1:0] dac_a_reg;
   logic [DAC_W-1:0] dac_b_reg;
   logic dac_a_load_reg;
   logic dac_b_load_reg;

   // Write channel: address and data are caught separately, in either order.
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0] wbyte_reg;
   logic wlane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_ok = idx_mapped(awaddr_reg, 1'b1);
   wire [4:0] wr_idx = awaddr_reg[6:2];
   wire wr_fire = do_write && wr_ok && wlane_reg;
   wire wr_soft = wr_fire && wr_idx == IDX_SOFT_TRIG;
   wire wr_dac_a_hi = wr_fire && wr_idx == IDX_DAC_A_HI;
   wire wr_dac_b_hi = wr_fire && wr_idx == IDX_DAC_B_HI;
   wire wr_cfg = wr_fire && wr_idx == IDX_TRIG_CFG;

   // Catch each channel and answer once both parts are in.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wbyte_reg <= BYTE_RESET;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (axil_req.awvalid && axil_rsp.awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= axil_req.awaddr;
         end
         if (axil_req.wvalid && axil_rsp.wready) begin
            w_held_reg <= 1'b1;
            wbyte_reg <= axil_req.wdata[7:0];
            wlane_reg <= axil_req.wstrb[0];
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && axil_req.bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Register stores; a DAC high byte write moves the code to the output, except DAC A in simultaneous mode, which waits for the DAC B high byte.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_reg <= '0;
         range_reg <= BYTE_RESET;
         oversample_reg <= BYTE_RESET;
         trig_cfg_reg <= CFG_RESET;
         dac_simul_reg <= 1'b0;
         armed_reg <= 1'b0;
         dac_a_lo_reg <= BYTE_RESET;
         dac_a_hi_reg <= '0;
         dac_b_lo_reg <= BYTE_RESET;
         dac_a_reg <= '0;
         dac_b_reg <= '0;
         dac_a_load_reg <= 1'b0;
         dac_b_load_reg <= 1'b0;
      end else begin
         dac_a_load_reg <= 1'b0;
         dac_b_load_reg <= 1'b0;
         if (wr_fire && wr_idx >= IDX_GAIN_FIRST && wr_idx <= IDX_GAIN_LAST) begin
            gain_reg[(wr_idx - IDX_GAIN_FIRST) * 8 +: 8] <= wbyte_reg;
         end
         if (wr_fire && wr_idx == IDX_RANGE) begin
            range_reg <= wbyte_reg;
         end
         if (wr_fire && wr_idx == IDX_OVERSAMPLE) begin
            oversample_reg <= wbyte_reg;
         end
         if (wr_fire && wr_idx == IDX_DAC_CTRL) begin
            dac_simul_reg <= wbyte_reg[DAC_SIMUL_BIT];
         end
         if (wr_cfg) begin
            trig_cfg_reg <= wbyte_reg;
            armed_reg <= (wbyte_reg[1:0] == SRC_TIMER) || (wbyte_reg[1:0] == SRC_EXT);
         end
         if (wr_fire && wr_idx == IDX_DAC_A_LO) begin
            dac_a_lo_reg <= wbyte_reg;
         end
         if (wr_fire && wr_idx == IDX_DAC_B_LO) begin
            dac_b_lo_reg <= wbyte_reg;
         end
         if (wr_dac_a_hi) begin
            dac_a_hi_reg <= wbyte_reg[3:0];
            if (!dac_simul_reg) begin
               dac_a_reg <= {wbyte_reg[3:0], dac_a_lo_reg};
               dac_a_load_reg <= 1'b1;
            end
         end
         if (wr_dac_b_hi) begin
            dac_b_reg <= {wbyte_reg[3:0], dac_b_lo_reg};
            dac_b_load_reg <= 1'b1;
            if (dac_simul_reg) begin
               dac_a_reg <= {dac_a_hi_reg, dac_a_lo_reg};
               dac_a_load_reg <= 1'b1;
            end
         end
      end
   end

   // Start sources: soft trigger, or the chosen edge of counter two when armed.
   wire [1:0] trig_src = trig_cfg_reg[1:0];
   wire edge_fall = trig_cfg_reg[CFG_EDGE_BIT];
   wire cnt2_edge = edge_fall ? (cnt2_prev_reg && !pin_sync_reg[5]) : (!cnt2_prev_reg && pin_sync_reg[5]);
   wire soft_start = wr_soft && trig_src == SRC_SOFT;
   wire timed_start = armed_reg && cnt2_edge;
   wire start_evt = soft_start || timed_start;

   // Sample queue storage and pointers.
   logic [SAMPLE_W-1:0] queue_mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire q_empty = count_reg == '0;
   wire q_full = count_reg == FULL_LEVEL;
   wire q_half = count_reg >= HALF_LEVEL;

   // Scan sequencer.
   seq_state_e state_reg;
   logic [3:0] ch_reg;
   logic [7:0] os_reg;
   logic conv_start_reg;
   wire [3:0] first_ch = range_reg[3:0];
   wire [3:0] last_ch = range_reg[7:4];
   wire scan_mode = trig_cfg_reg[CFG_SCAN_BIT];
   wire push = state_reg == SEQ_WAIT && conv_done && !q_full;
   wire more_os = os_reg != oversample_reg;
   wire more_ch = scan_mode && ch_reg != last_ch;

   // Each start walks first to last channel in scan mode, else the first only, each sampled oversample plus one times.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= SEQ_IDLE;
         ch_reg <= '0;
         os_reg <= '0;
         conv_start_reg <= 1'b0;
      end else begin
         conv_start_reg <= 1'b0;
         unique case (state_reg)
            SEQ_IDLE: begin
               if (start_evt) begin
                  ch_reg <= first_ch;
                  os_reg <= '0;
                  conv_start_reg <= 1'b1;
                  state_reg <= SEQ_WAIT;
               end
            end
            SEQ_WAIT: begin
               if (conv_done) begin
                  if (more_os) begin
                     os_reg <= os_reg + 8'h01;
                     conv_start_reg <= 1'b1;
                  end else if (more_ch) begin
                     ch_reg <= ch_reg + 4'h1;
                     os_reg <= '0;
                     conv_start_reg <= 1'b1;
                  end else begin
                     state_reg <= SEQ_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Read channel; a word read at index zero pops the queue.
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire rd_take = axil_req.arvalid && !rvalid_reg;
   wire [4:0] rd_idx = axil_req.araddr[6:2];
   wire rd_ok = idx_mapped(axil_req.araddr, 1'b0);
   wire pop = rd_take && rd_ok && rd_idx == IDX_RESULT && !q_empty;
   wire [SAMPLE_W-1:0] head = queue_mem[rd_ptr_reg];
   wire [7:0] status_byte = {q_full, !q_half, !q_empty, pin_sync_reg[4:0]};
   wire [31:0] rd_mux = !rd_ok ? 32'h0000_0000 :
                        rd_idx == IDX_RESULT ? {16'h0000, head} :
                        rd_idx == IDX_SOFT_TRIG ? {24'h00_0000, head[15:8]} :
                        {24'h00_0000, status_byte};

   always_ff @(posedge aclk) begin
      if (push) begin
         queue_mem[wr_ptr_reg] <= conv_data;
      end
   end

   // Pointer and level bookkeeping; a push while full is dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
         if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_reg && axil_req.rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Outputs.
   assign axil_rsp.awready = !aw_held_reg && !bvalid_reg;
   assign axil_rsp.wready = !w_held_reg && !bvalid_reg;
   assign axil_rsp.bvalid = bvalid_reg;
   assign axil_rsp.bresp = bresp_reg;
   assign axil_rsp.arready = !rvalid_reg;
   assign axil_rsp.rvalid = rvalid_reg;
   assign axil_rsp.rdata = rdata_reg;
   assign axil_rsp.rresp = rresp_reg;
   assign conv_start = conv_start_reg;
   assign conv_channel = ch_reg;
   assign conv_gain = gain_reg[{ch_reg, 1'b0} +: 2];
   assign counter2_clk = counter1_out;
   assign counter_zero_clock_select = trig_cfg_reg[CFG_CLK_BIT];
   assign dac_a_code = dac_a_reg;
   assign dac_b_code = dac_b_reg;
   assign dac_a_load = dac_a_load_reg;
   assign dac_b_load = dac_b_load_reg;
   assign scan_busy = state_reg == SEQ_WAIT;

   // Checks.
   sequence s_word_pop;
      rd_take && rd_ok && rd_idx == IDX_RESULT && !q_empty;
   endsequence
   sequence s_chan_end;
      state_reg == SEQ_WAIT && conv_done && !more_os && more_ch;
   endsequence
   a_word_read_pop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_word_pop |=> rd_ptr_reg == $past(rd_ptr_reg) + AW'(1)) else $error("Word read did not pop.");
   a_high_byte_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_SOFT_TRIG |=> $stable(rd_ptr_reg)) else $error("High byte read popped.");
   a_soft_start_once: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_soft && trig_src == SRC_SOFT && state_reg == SEQ_IDLE |=> conv_start ##1 !conv_start)
      else $error("Soft trigger did not start once.");
   a_unarmed_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == SEQ_IDLE && !armed_reg && !wr_soft |=> !conv_start) else $error("Start while unarmed.");
   a_scan_next_chan: assert property (@(posedge aclk) disable iff (!aresetn)
      s_chan_end |=> conv_start && conv_channel == $past(ch_reg) + 4'h1) else $error("Scan skipped a channel.");
   a_dac_deferred: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dac_a_hi && dac_simul_reg |=> $stable(dac_a_code) && !dac_a_load) else $error("DAC A not deferred.");
   a_dac_joint: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dac_b_hi && dac_simul_reg |=> dac_a_load && dac_b_load) else $error("DACs not updated together.");
   a_status_empty: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_STATUS && rd_ok |=> rdata_reg[ST_EMPTY_N_BIT] == ($past(count_reg) != '0))
      else $error("Not-empty flag wrong.");
   a_status_half: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_STATUS && rd_ok |=> rdata_reg[ST_HALF_N_BIT] == ($past(count_reg) < HALF_LEVEL))
      else $error("Half flag wrong.");
   a_status_full: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_idx == IDX_STATUS && rd_ok |=> rdata_reg[ST_FULL_BIT] == ($past(count_reg) == FULL_LEVEL))
      else $error("Full flag wrong.");
   // A pin edge seen while armed and idle must start the first channel one cycle later.
   sequence s_pin_start;
      state_reg == SEQ_IDLE && armed_reg && cnt2_edge;
   endsequence
   a_pin_start_now: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pin_start |=> conv_start && conv_channel == $past(first_ch)) else $error("Pin edge did not start.");
   // The level never passes the depth, so a push into a full queue must leave the write side alone.
   a_queue_bound: assert property (@(posedge aclk) disable iff (!aresetn)
      count_reg <= FULL_LEVEL) else $error("Queue level above depth.");
   a_full_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      q_full && !pop |=> $stable(wr_ptr_reg) && count_reg == FULL_LEVEL) else $error("Full queue took a push.");
   // Without simultaneous mode each DAC takes its staged low byte at the high byte write.
   a_dac_a_now: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dac_a_hi && !dac_simul_reg |=> dac_a_load && dac_a_code[7:0] == $past(dac_a_lo_reg) &&
      dac_a_code[11:8] == dac_a_hi_reg) else $error("DAC A did not update.");
   a_dac_b_now: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dac_b_hi |=> dac_b_load && dac_b_code[7:0] == $past(dac_b_lo_reg)) else $error("DAC B did not update.");
   // Source codes with unequal bits arm pin starts; equal bits disarm them, so code 11 never starts.
   a_cfg_arm: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cfg && wbyte_reg[1] != wbyte_reg[0] |=> armed_reg) else $error("Pin start not armed.");
   a_cfg_disarm: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cfg && wbyte_reg[1] == wbyte_reg[0] |=> !armed_reg) else $error("Pin start left armed.");
   // Single channel mode stops after the last oversample of the first channel.
   sequence s_single_end;
      state_reg == SEQ_WAIT && conv_done && !more_os && !scan_mode;
   endsequence
   a_single_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_single_end |=> !scan_busy && !conv_start) else $error("Single channel mode ran on.");
endmodule : adc_dac_control_regs

// *** test/adc_dac_control_regs_test.sv ***
// Self-checking bench for the converter control block: register bus, scan, queue, DACs, status.
// Assumes the design package is compiled first; the bench plays the converter and the host.
`timescale 1ns/1ns
module adc_dac_control_regs_test;
   import adc_dac_pkg::*;
   typedef struct packed {logic wr; logic [4:0] idx; logic [7:0] d; logic [1:0] resp; logic [7:0] rd;} row_s;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   axil_req_s req = '0;
   axil_rsp_s rsp;
   logic conv_start, conv_done = 1'b0, counter1_out = 1'b0, counter2_out = 1'b0, counter2_clk, clk0_sel;
   logic [3:0] conv_channel;
   logic [1:0] conv_gain;
   logic [15:0] conv_data = 16'h0000;
   logic [4:0] jumpers = 5'h15;
   logic [11:0] dac_a_code, dac_b_code;
   logic dac_a_load, dac_b_load, scan_busy;
   logic [15:0] res_q[$];
   logic [5:0] conv_q[$];
   logic [7:0] seq = 8'h00;
   logic [1:0] busy_cnt = 2'h0;
   int n_fail = 0, n_compared = 0, loads_a = 0, loads_b = 0;
   row_s rows[6] = '{'{1'b1, 5'h12, 8'h00, RESP_SLVERR, 8'h00}, '{1'b1, 5'h08, 8'h00, RESP_SLVERR, 8'h00},
      '{1'b0, 5'h02, 8'h00, RESP_SLVERR, 8'h00}, '{1'b0, 5'h13, 8'h00, RESP_SLVERR, 8'h00},
      '{1'b0, 5'h12, 8'h00, RESP_OKAY, 8'h55}, '{1'b1, 5'h11, 8'h10, RESP_OKAY, 8'h00}};

   always #4 aclk = ~aclk;

   adc_dac_control_regs #(.DEPTH(8)) dut_u (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_done(conv_done),
      .conv_data(conv_data), .counter1_out(counter1_out), .counter2_out(counter2_out),
      .counter2_clk(counter2_clk), .counter_zero_clock_select(clk0_sel), .jumper_bipolar(jumpers[0]),
      .jumper_single_ended(jumpers[1]), .gain_group_jumper(jumpers[2]), .first_dac_range_flag(jumpers[3]),
      .second_dac_range_flag(jumpers[4]), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
      .dac_a_load(dac_a_load), .dac_b_load(dac_b_load), .scan_busy(scan_busy));

   // Converter stand-in: answers each start two cycles later and logs channel and gain.
   always @(posedge aclk) begin
      conv_done <= 1'b0;
      if (dac_a_load === 1'b1) loads_a = loads_a + 1;
      if (dac_b_load === 1'b1) loads_b = loads_b + 1;
      if (busy_cnt != 2'h0) begin
         busy_cnt <= busy_cnt - 2'h1;
         if (busy_cnt == 2'h1) begin
            conv_done <= 1'b1;
            conv_data <= {conv_channel, 4'h0, seq};
            if (res_q.size() < 8) res_q.push_back({conv_channel, 4'h0, seq});
            seq <= seq + 8'h01;
         end
      end else if (conv_start === 1'b1) begin
         busy_cnt <= 2'h2;
         conv_q.push_back({conv_gain, conv_channel});
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Bus handshake, start, load, busy, clock select and DAC code outputs, looked at on the edge that releases reset.
   task automatic chk_reset();
      chk({22'h0, rsp.awready, rsp.wready, rsp.arready, rsp.bvalid, rsp.rvalid, clk0_sel, scan_busy, dac_a_load,
         dac_b_load, conv_start}, 32'h0000_0380);
      chk({8'h00, dac_a_code, dac_b_code}, 32'h0000_0000);
   endtask : chk_reset

   // Write with address and data offered together; each is released on its own handshake.
   task automatic axi_write(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
      int t;
      @(posedge aclk);
      req.awaddr <= {1'b0, idx, 2'b00};
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) break;
      end
      req.bready <= 1'b0;
      chk({29'h0, rsp.bvalid, rsp.bresp}, {29'h0, 1'b1, er});
   endtask : axi_write

   task automatic axi_read(input logic [4:0] idx, input logic [15:0] ed, input logic [1:0] er);
      int t;
      @(posedge aclk);
      req.araddr <= {1'b0, idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) break;
      end
      req.rready <= 1'b0;
      chk({rsp.rvalid, rsp.rresp, rsp.rdata[28:0]}, {1'b1, er, 13'h0000, ed});
   endtask : axi_read

   // Waits for the sequencer to finish a burst, bounded so a stuck scan ends as a mismatch.
   task automatic wait_idle();
      int t;
      repeat (8) @(posedge aclk);
      for (t = 0; t < 300 && scan_busy !== 1'b0; t++) @(posedge aclk);
      chk({31'h0, scan_busy}, 32'h0);
   endtask : wait_idle

   task automatic pin_edge();
      @(posedge aclk);
      counter2_out <= 1'b1;
      wait_idle();
      counter2_out <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pin_edge

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      stop_test();
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      chk_reset();
      // Table of bus cases: refusals, reset status and the counter zero clock select.
      foreach (rows[i]) begin
         if (rows[i].wr) axi_write(rows[i].idx, rows[i].d, rows[i].resp);
         else axi_read(rows[i].idx, {8'h00, rows[i].rd}, rows[i].resp);
      end
      chk({31'h0, clk0_sel}, 32'h1);
      @(posedge aclk);
      counter1_out <= 1'b1;
      @(posedge aclk);
      chk({31'h0, counter2_clk}, 32'h1);
      // Scan from channel 2 to 3 with one extra oversample, started by software.
      axi_write(5'h02, 8'hE4, RESP_OKAY);
      axi_write(5'h06, 8'h32, RESP_OKAY);
      axi_write(5'h07, 8'h01, RESP_OKAY);
      axi_write(5'h11, 8'h04, RESP_OKAY);
      axi_write(5'h01, 8'h00, RESP_OKAY);
      wait_idle();
      chk(conv_q.size(), 4);
      foreach (conv_q[i]) chk({26'h0, conv_q[i]}, (i < 2) ? 32'h22 : 32'h33);
      axi_read(5'h12, 16'h0035, RESP_OKAY);
      // Byte order: high byte first leaves the head in place, then the word read pops it.
      axi_read(5'h01, {8'h00, res_q[0][15:8]}, RESP_OKAY);
      repeat (4) axi_read(5'h00, res_q.pop_front(), RESP_OKAY);
      axi_read(5'h12, 16'h0055, RESP_OKAY);
      // Pin-started single channel conversions until the queue refuses more.
      conv_q.delete();
      axi_write(5'h11, 8'h01, RESP_OKAY);
      repeat (4) pin_edge();
      chk(conv_q.size(), 8);
      axi_read(5'h12, 16'h00B5, RESP_OKAY);
      pin_edge();
      axi_read(5'h12, 16'h00B5, RESP_OKAY);
      // Falling edge select: a rise does nothing, the fall starts a conversion.
      repeat (8) axi_read(5'h00, res_q.pop_front(), RESP_OKAY);
      conv_q.delete();
      axi_write(5'h11, 8'h0A, RESP_OKAY);
      pin_edge();
      wait_idle();
      chk(conv_q.size(), 2);
      // Source code 11 leaves pin starts unarmed.
      axi_write(5'h11, 8'h03, RESP_OKAY);
      pin_edge();
      chk(conv_q.size(), 2);
      // DACs: immediate update, then simultaneous update held until the second DAC.
      axi_write(5'h10, 8'h00, RESP_OKAY);
      axi_write(5'h0C, 8'h34, RESP_OKAY);
      axi_write(5'h0D, 8'h0B, RESP_OKAY);
      chk({20'h0, dac_a_code}, 32'hB34);
      axi_write(5'h10, 8'h01, RESP_OKAY);
      axi_write(5'h0C, 8'hCD, RESP_OKAY);
      axi_write(5'h0D, 8'h0A, RESP_OKAY);
      chk({20'h0, dac_a_code}, 32'hB34);
      axi_write(5'h0E, 8'h21, RESP_OKAY);
      axi_write(5'h0F, 8'h05, RESP_OKAY);
      @(posedge aclk);
      chk({dac_a_code, dac_b_code}, 32'hACD521);
      chk(loads_a * 16 + loads_b, 32'h21);
      // Mid-run reset with new jumpers: outputs and queue level clear, the pins still follow their inputs.
      jumpers <= 5'h0A;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk_reset();
      axi_read(5'h12, 16'h004A, RESP_OKAY);
      stop_test();
   end
endmodule : adc_dac_control_regs_test
